//--- src/accumulator_transfer_ops.sv
`timescale 1ns/1ps
// Contract
// RULE1: General-register transfer copies all four accumulator bits, accumulator kept.
// RULE2: General-register transfer leaves carry alone and never skips.
// RULE3: Port-structure transfer loads accumulator into port output structure register.
// RULE4: Data-pointer transfer copies accumulator bits 2..0 only, bit 3 ignored.
// RULE5: Wide load puts general register into wide bits 7..4.
// RULE6: Wide load puts accumulator into wide bits 3..0, same instruction.
// RULE7: Each transfer is one word, one cycle, carry unchanged, no skip.
module accumulator_transfer_ops (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic [9:0] instr_word,
   input wire logic [3:0] acc,
   input wire logic carry_in,
   output logic [3:0] general_reg,
   output logic [3:0] port_output_structure_reg,
   output logic [2:0] data_pointer,
   output logic [7:0] wide_reg,
   output logic carry_flag,
   output logic skip_next,
   output logic done
);
   xfer_pkg::op_type op;
   wire logic hit_general;
   wire logic hit_port;
   wire logic hit_pointer;
   wire logic hit_wide;
   wire logic load_general;
   wire logic load_port;
   wire logic load_pointer;
   wire logic load_wide;
   wire logic [2:0] next_pointer;
   wire logic [7:0] next_wide;
   wire logic [3:0] gen_q;
   wire logic [3:0] port_q;

   assign hit_general = instr_valid && instr_word == xfer_pkg::code_acc_to_general;
   assign hit_port = instr_valid && instr_word == xfer_pkg::code_acc_to_port_struct;
   assign hit_pointer = instr_valid && instr_word == xfer_pkg::code_acc_to_data_pointer;
   assign hit_wide = instr_valid && instr_word == xfer_pkg::code_load_wide;
   assign op = hit_general ? xfer_pkg::op_acc_to_general_reg :
               hit_port ? xfer_pkg::op_acc_to_port_struct :
               hit_pointer ? xfer_pkg::op_acc_to_data_pointer :
               hit_wide ? xfer_pkg::op_load_wide_register : xfer_pkg::op_none;
   // A low clock enable masks every load, so a stalled core keeps its state
   assign load_general = ce && op == xfer_pkg::op_acc_to_general_reg; // [RULE1]
   assign load_port = ce && op == xfer_pkg::op_acc_to_port_struct; // [RULE3]
   assign load_pointer = ce && op == xfer_pkg::op_acc_to_data_pointer; // [RULE4]
   assign load_wide = ce && op == xfer_pkg::op_load_wide_register; // [RULE5] [RULE6]
   // Accumulator bit 3 never reaches the pointer
   assign next_pointer = acc[2:0]; // [RULE4]
   // Both halves formed together so the wide load finishes in one cycle
   assign next_wide = {gen_q, acc}; // [RULE5] [RULE6]

   nibble_reg #(.width(4)) u_general (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .load(load_general), // [RULE1]
      .d(acc),
      .q(gen_q)
   );

   property p_general;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && hit_general |=> general_reg == $past(acc);
   endproperty
   a_general: assert property (p_general) else $error("general load wrong"); // [RULE1]

   property p_general_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && !hit_general |=> $stable(general_reg);
   endproperty
   a_general_hold: assert property (p_general_hold) else $error("general moved"); // [RULE1]

   nibble_reg #(.width(4)) u_port (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .load(load_port), // [RULE3]
      .d(acc),
      .q(port_q)
   );

   property p_port;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && hit_port |=> port_output_structure_reg == $past(acc);
   endproperty
   a_port: assert property (p_port) else $error("port struct load wrong"); // [RULE3]

   property p_port_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && !hit_port |=> $stable(port_output_structure_reg);
   endproperty
   a_port_hold: assert property (p_port_hold) else $error("port struct moved"); // [RULE3]

   assign general_reg = gen_q;
   assign port_output_structure_reg = port_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         data_pointer <= xfer_pkg::reset_pointer;
      end else if (load_pointer) begin
         data_pointer <= next_pointer; // [RULE4]
      end
   end

   property p_pointer;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && hit_pointer |=> data_pointer == $past(acc[2:0]);
   endproperty
   a_pointer: assert property (p_pointer) else $error("pointer load wrong"); // [RULE4]

   property p_pointer_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && !hit_pointer |=> $stable(data_pointer);
   endproperty
   a_pointer_hold: assert property (p_pointer_hold) else $error("pointer moved"); // [RULE4]

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wide_reg <= xfer_pkg::reset_wide;
      end else if (load_wide) begin
         wide_reg <= next_wide; // [RULE5] [RULE6]
      end
   end

   property p_wide_hi;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && hit_wide |=> wide_reg[7:4] == $past(gen_q);
   endproperty
   a_wide_hi: assert property (p_wide_hi) else $error("wide high wrong"); // [RULE5]

   property p_wide_lo;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && hit_wide |=> wide_reg[3:0] == $past(acc);
   endproperty
   a_wide_lo: assert property (p_wide_lo) else $error("wide low wrong"); // [RULE6]

   property p_wide_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && !hit_wide |=> $stable(wide_reg);
   endproperty
   a_wide_hold: assert property (p_wide_hold) else $error("wide moved"); // [RULE5] [RULE6]

   property p_wide_chain;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && hit_general ##1 ce && hit_wide |=> wide_reg[7:4] == $past(acc, 2);
   endproperty
   a_wide_chain: assert property (p_wide_chain) else $error("wide chain wrong"); // [RULE5]

   // Carry is only echoed and skip never raised: transfers touch neither
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         carry_flag <= xfer_pkg::reset_flag;
         skip_next <= xfer_pkg::reset_flag;
         done <= xfer_pkg::reset_flag;
      end else if (ce) begin
         carry_flag <= carry_in; // [RULE2] [RULE7]
         skip_next <= 1'h0; // [RULE2] [RULE7]
         done <= op != xfer_pkg::op_none; // [RULE7]
      end
   end

   property p_noskip;
      @(posedge ref_clk) disable iff (!rst_b) $past(ce) |-> !skip_next;
   endproperty
   a_noskip: assert property (p_noskip) else $error("skip raised"); // [RULE2]

   property p_carry;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && instr_valid |=> carry_flag == $past(carry_in)
            && done == $past(op != xfer_pkg::op_none);
   endproperty
   a_carry: assert property (p_carry) else $error("carry or done wrong"); // [RULE7]

   property p_idle;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && !hit_general && !hit_port && !hit_pointer && !hit_wide |=> !done;
   endproperty
   a_idle: assert property (p_idle) else $error("done without transfer"); // [RULE7]

   property p_done_hit;
      @(posedge ref_clk) disable iff (!rst_b)
         ce && (hit_general || hit_port || hit_pointer || hit_wide) |=> done;
   endproperty
   a_done_hit: assert property (p_done_hit) else $error("transfer without done"); // [RULE7]

   // Clock enable low freezes everything
   property p_hold;
      @(posedge ref_clk) disable iff (!rst_b)
         !ce ##1 rst_b |-> $stable(wide_reg) && $stable(data_pointer);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved while frozen"); // [RULE7]

   property p_freeze;
      @(posedge ref_clk) disable iff (!rst_b)
         !ce |=> $stable(general_reg) && $stable(port_output_structure_reg)
            && $stable(carry_flag) && $stable(done) && $stable(skip_next);
   endproperty
   a_freeze: assert property (p_freeze) else $error("output moved while frozen"); // [RULE7]

   property p_reset;
      @(posedge ref_clk)
         !rst_b |=> general_reg == xfer_pkg::reset_nibble
            && port_output_structure_reg == xfer_pkg::reset_nibble
            && data_pointer == xfer_pkg::reset_pointer && wide_reg == xfer_pkg::reset_wide
            && carry_flag == xfer_pkg::reset_flag && done == xfer_pkg::reset_flag;
   endproperty
   a_reset: assert property (p_reset) else $error("reset value wrong"); // [RULE7]

   c_general: cover property (@(posedge ref_clk) ce && hit_general);
   c_port: cover property (@(posedge ref_clk) ce && hit_port);
   c_pointer: cover property (@(posedge ref_clk) ce && hit_pointer);
   c_wide: cover property (@(posedge ref_clk) ce && hit_general ##1 ce && hit_wide);
   c_frozen: cover property (@(posedge ref_clk) !ce && instr_valid);
endmodule

//--- src/nibble_reg.sv
`timescale 1ns/1ps
module nibble_reg #(
   parameter int width = 4
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic load,
   input wire logic [width-1:0] d,
   output logic [width-1:0] q
);
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= '0;
      end else if (ce && load) begin
         q <= d;
      end
   end
endmodule

//--- src/xfer_pkg.sv
package xfer_pkg;
   localparam int word_width = 10;
   localparam int acc_width = 4;
   localparam int ptr_width = 3;
   localparam int wide_width = 8;
   // Opcodes of the four transfers
   localparam logic [9:0] code_acc_to_general = 10'h00e;
   localparam logic [9:0] code_acc_to_port_struct = 10'h2a8;
   localparam logic [9:0] code_acc_to_data_pointer = 10'h029;
   localparam logic [9:0] code_load_wide = 10'h01a;
   // Values after reset
   localparam logic [3:0] reset_nibble = 4'h0;
   localparam logic [2:0] reset_pointer = 3'h0;
   localparam logic [7:0] reset_wide = 8'h00;
   localparam logic reset_flag = 1'h0;
   localparam logic [1:0] cycles_per_op = 2'h1;
   typedef enum logic [2:0] {
      op_none,
      op_acc_to_general_reg,
      op_acc_to_port_struct,
      op_acc_to_data_pointer,
      op_load_wide_register
   } op_type;
endpackage

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, instr_valid = 1'b0, carry_in = 1'b0;
   logic [9:0] instr_word = 10'h000;
   logic [3:0] acc = 4'h0, general_reg, port_output_structure_reg, eg = 4'h0, ep = 4'h0;
   logic [2:0] data_pointer, ed = 3'h0;
   logic [7:0] wide_reg, ew = 8'h00;
   logic carry_flag, skip_next, done, ec = 1'b0, edn = 1'b0;
   int failures = 0, samples_checked = 0;
   // Code and accumulator pairs, back to back
   logic [13:0] rows[8] = '{{10'h00e, 4'h5}, {10'h01a, 4'h3}, {10'h2a8, 4'ha}, {10'h029, 4'hf},
      {10'h029, 4'h8}, {10'h00e, 4'hc}, {10'h00e, 4'h6}, {10'h01a, 4'h9}};
   always #2.5 ref_clk = ~ref_clk;
   accumulator_transfer_ops accumulator_transfer_ops_inst (.ref_clk, .rst_b, .ce, .instr_valid,
      .instr_word, .acc, .carry_in, .general_reg, .port_output_structure_reg, .data_pointer,
      .wide_reg, .carry_flag, .skip_next, .done);
   task chk(logic [7:0] got, logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results;
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Drives one cycle, keeps the expected state, checks after the edge
   task run(logic c, logic v, logic [9:0] w, logic [3:0] a, logic cy);
      ce = c;
      instr_valid = v;
      instr_word = w;
      acc = a;
      carry_in = cy;
      if (c) edn = v;
      if (c) ec = cy;
      if (c && v) begin
         case (w)
            xfer_pkg::code_acc_to_general: eg = a;
            xfer_pkg::code_acc_to_port_struct: ep = a;
            xfer_pkg::code_acc_to_data_pointer: ed = a[2:0];
            xfer_pkg::code_load_wide: ew = {eg, a};
            default: edn = 1'b0;
         endcase
      end
      @(posedge ref_clk);
      #1;
      chk(general_reg, eg);
      chk(port_output_structure_reg, ep);
      chk(data_pointer, ed);
      chk(wide_reg[7:4], ew[7:4]);
      chk(wide_reg[3:0], ew[3:0]);
      chk(carry_flag, ec);
      chk(skip_next, 1'b0);
      chk(done, edn);
   endtask
   initial begin
      #2000;
      failures++;
      results();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      #1;
      chk({general_reg, port_output_structure_reg}, 8'h00);
      chk(wide_reg, 8'h00);
      chk({data_pointer, carry_flag, skip_next, done}, 8'h00);
      rst_b = 1'b1;
      for (int i = 0; i < 8; i++) begin
         run(1'b1, 1'b1, rows[i][13:4], rows[i][3:0], i[0]);
      end
      run(1'b1, 1'b1, 10'h3ff, 4'h7, 1'b1);
      run(1'b1, 1'b0, 10'h00e, 4'h2, 1'b0);
      run(1'b0, 1'b1, 10'h2a8, 4'h1, 1'b1);
      run(1'b1, 1'b1, 10'h2a8, 4'h0, 1'b1);
      run(1'b1, 1'b0, 10'h000, 4'h0, 1'b0);
      // Reset in mid-run beats a transfer offered in the same cycle
      rst_b = 1'h0;
      instr_valid = 1'h1;
      instr_word = xfer_pkg::code_acc_to_port_struct;
      acc = 4'h9;
      @(posedge ref_clk);
      #1;
      chk({general_reg, port_output_structure_reg}, 8'h00);
      chk(wide_reg, 8'h00);
      chk({data_pointer, carry_flag, skip_next, done}, 8'h00);
      rst_b = 1'h1;
      eg = 4'h0;
      ep = 4'h0;
      ed = 3'h0;
      ew = 8'h00;
      ec = 1'h0;
      edn = 1'h0;
      run(1'b1, 1'b1, xfer_pkg::code_load_wide, 4'hb, 1'b1);
      run(1'b1, 1'b1, xfer_pkg::code_acc_to_data_pointer, 4'hd, 1'b0);
      results();
   end
endmodule
